/* File: rtl/acsc_pkg.sv */
// constants, types and field layout of the system control register pair
// Notes on behaviour
// - sleep rate field: 00 50 Hz, 01 12.5 Hz, 10 0.05 Hz, 11 1.56 Hz; default 00.
// - in auto-sleep the output rate and block rates follow the sleep rate field.
// - wake rate codes 000..111 give 800 Hz down to 1.56 Hz; default 000.
// - mode bit 0 is standby (default), 1 is active.
// - fast-read set makes address auto-increment skip low data bytes; default off.
// - self-test bit set shifts the axis outputs; default off.
// - writing 1 to software reset resets the device at once in any mode; the code ignores the write while booting.
// - software reset returns every register to its default.
// - software reset also resets the serial communication logic.
// - reset bit clears itself when boot ends and always reads as zero.
// - auto-sleep enable permits sleep; when clear only standby and wake exist.
// - wake and sleep power scheme fields pick one of four oversampling modes.
// - normal and low noise low power oversampling ratios follow the rate.
// - high resolution and low power oversampling ratios follow the rate.
// - with auto-sleep, sleep after inactivity period of 320 ms steps, 640 ms at 1.56 Hz.
// - only orientation and motion events restart the timer; they, or clearing auto-sleep enable, wake the device.
package acsc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register map and fields
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h2A;
  localparam logic [7:0] ADDR_CTRL_TWO  = 8'h2B;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] CTRL_ONE_WMASK = 8'hFB;
  localparam logic [7:0] CTRL_TWO_WMASK = 8'hDF;
  localparam logic [7:0] CTRL_TWO_RMASK = 8'h9F;
  localparam int BIT_MODE      = 0;
  localparam int BIT_FAST_READ = 1;
  localparam int POS_WAKE_RATE = 3;
  localparam int POS_SLP_RATE  = 6;
  localparam int POS_WAKE_PS   = 0;
  localparam int BIT_SLP_EN    = 2;
  localparam int POS_SLP_PS    = 3;
  localparam int BIT_SW_RESET  = 6;
  localparam int BIT_SELF_TEST = 7;
  // low data byte addresses skipped by fast read
  localparam logic [7:0] ADDR_LSB_X = 8'h02;
  localparam logic [7:0] ADDR_LSB_Y = 8'h04;
  localparam logic [7:0] ADDR_LSB_Z = 8'h06;
  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int BASE_PERIOD_NS = 1250000;  // 800 Hz period
  localparam int BASE_CYCLES    = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_MS        = 320;
  localparam int STEP_SLOW_MS   = 640;
  localparam logic [9:0] STEP_TICKS      = 10'(STEP_MS * 1000000 / BASE_PERIOD_NS);
  localparam logic [9:0] STEP_SLOW_TICKS = 10'(STEP_SLOW_MS * 1000000 / BASE_PERIOD_NS);
  localparam logic [4:0] BOOT_CYCLES     = 5'h10;
  localparam logic [2:0] RATE_SLOWEST    = 3'h7;
  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ACSC_STANDBY = 2'b00,
    ACSC_WAKE    = 2'b01,
    ACSC_SLEEP   = 2'b10,
    ACSC_BOOT    = 2'b11
  } acsc_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acsc_req_t;

  typedef struct packed {
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    acsc_mode_t  mode;
    logic [14:0] base_cnt;
    logic        base_tick;
    logic [13:0] rate_cnt;
    logic        sample_tick;
    logic [9:0]  step_tick;
    logic [7:0]  steps;
    logic [4:0]  boot_cnt;
    logic        serial_reset;
    logic        sleeping;
    logic [10:0] os_ratio;
    logic [1:0]  scheme;
    logic [7:0]  rdata;
    logic [7:0]  next_addr;
  } acsc_state_t;
endpackage

/* File: rtl/acsc_regs.sv */
// system control register pair with rate, sleep and reset control
module acsc_regs
  import acsc_pkg::*;
#(
  parameter int BASE_TICK_CYCLES = BASE_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // register access from the serial front end
  input  wire acsc_req_t   req_i,
  input  wire logic [7:0]  inactivity_period_i,
  input  wire logic        activity_i,
  // register read side
  output logic [7:0]       rdata_o,
  output logic [7:0]       next_addr_o,
  output logic             serial_reset_o,
  // sensing control
  output logic             sample_tick_o,
  output logic             sleeping_o,
  output logic             booting_o,
  output logic [10:0]      os_ratio_o,
  output logic [1:0]       power_scheme_o,
  output logic             self_test_o,
  output logic             fast_read_o
);
  acsc_state_t s;
  acsc_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  // rate index: 0 is 1.56 Hz row, 7 is 800 Hz row
  function automatic logic [2:0] wake_row(input logic [2:0] code);
    return 3'h7 - code;
  endfunction

  function automatic logic [2:0] sleep_row(input logic [1:0] code);
    case (code)
      2'b00:   return 3'h3;
      2'b01:   return 3'h2;
      default: return 3'h0;  // 0.05 Hz uses the slowest row
    endcase
  endfunction

  // period in 1.25 ms base ticks
  function automatic logic [13:0] period_ticks(input logic sleep, input logic [1:0] sc,
                                               input logic [2:0] dc);
    logic [13:0] t;
    t = 14'h0001;
    if (sleep) begin
      case (sc)
        2'b00:   t = 14'h0010;
        2'b01:   t = 14'h0040;
        2'b10:   t = 14'h3E80;
        default: t = 14'h0200;
      endcase
    end else begin
      case (dc)
        3'h5:    t = 14'h0040;
        3'h6:    t = 14'h0080;
        3'h7:    t = 14'h0200;
        default: t = 14'(14'h0001 << dc);
      endcase
    end
    return t;
  endfunction

  function automatic logic [10:0] os_ratio(input logic [1:0] ps, input logic [2:0] row);
    logic [10:0] r;
    r = 11'h002;
    case (ps)
      2'b00: begin
        case (row)
          3'h0:    r = 11'h080;
          3'h1:    r = 11'h020;
          3'h2:    r = 11'h010;
          3'h7:    r = 11'h002;
          default: r = 11'h004;
        endcase
      end
      2'b01: begin
        case (row)
          3'h0:    r = 11'h020;
          3'h1:    r = 11'h008;
          3'h7:    r = 11'h002;
          default: r = 11'h004;
        endcase
      end
      // high resolution, quartered between rows 0 and 1 and between rows 2 and 3, halved elsewhere
      2'b10: r = (row == 3'h0) ? 11'h400 : 11'((row < 3'h3 ? 11'h200 : 11'h100) >> row);
      default: begin
        case (row)
          3'h0:    r = 11'h010;
          3'h1:    r = 11'h004;
          default: r = 11'h002;
        endcase
      end
    endcase
    return r;
  endfunction

  function automatic logic is_low_byte(input logic [7:0] a);
    return (a == ADDR_LSB_X) || (a == ADDR_LSB_Y) || (a == ADDR_LSB_Z);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic        in_sleep;
    logic        run;
    logic [13:0] per;
    logic [9:0]  step_len;
    logic [7:0]  inc;
    in_sleep = 1'b0;
    run      = 1'b0;
    per      = 14'h0001;
    step_len = STEP_TICKS;
    inc      = 8'h00;
    next_s   = s;
    next_s.sample_tick  = 1'b0;
    next_s.base_tick    = 1'b0;
    next_s.serial_reset = 1'b0;

    // sleep overrides the wake rate for every block
    in_sleep = (s.mode == ACSC_SLEEP);
    run      = (s.mode == ACSC_WAKE) || in_sleep;
    per      = period_ticks(in_sleep, s.ctrl_one[POS_SLP_RATE +: 2],
                            s.ctrl_one[POS_WAKE_RATE +: 3]);

    // base 1.25 ms enable, only while sampling
    if (run) begin
      if (s.base_cnt == 15'(BASE_TICK_CYCLES - 1)) begin
        next_s.base_cnt  = 15'h0000;
        next_s.base_tick = 1'b1;
      end else begin
        next_s.base_cnt = s.base_cnt + 15'h0001;
      end
    end else begin
      next_s.base_cnt = 15'h0000;
    end

    // sample enable at the selected rate
    if (run && s.base_tick) begin
      if (s.rate_cnt >= per - 14'h0001) begin
        next_s.rate_cnt    = 14'h0000;
        next_s.sample_tick = 1'b1;
      end else begin
        next_s.rate_cnt = s.rate_cnt + 14'h0001;
      end
    end

    // inactivity steps, longer when the wake rate is slowest
    if (s.ctrl_one[POS_WAKE_RATE +: 3] == RATE_SLOWEST) begin
      step_len = STEP_SLOW_TICKS;
    end
    if (s.mode == ACSC_WAKE && s.base_tick) begin
      if (s.step_tick == step_len - 10'h001) begin
        next_s.step_tick = 10'h000;
        if (s.steps != 8'hFF) begin
          next_s.steps = s.steps + 8'h01;
        end
      end else begin
        next_s.step_tick = s.step_tick + 10'h001;
      end
    end

    // mode sequencing
    case (s.mode)
      ACSC_STANDBY: begin
        if (s.ctrl_one[BIT_MODE]) begin
          next_s.mode = ACSC_WAKE;
        end
      end
      ACSC_WAKE: begin
        // sleep only when enabled and the period has run out
        if (s.ctrl_two[BIT_SLP_EN] && s.steps >= inactivity_period_i && !activity_i) begin
          next_s.mode     = ACSC_SLEEP;
          next_s.rate_cnt = 14'h0000;
        end
      end
      ACSC_SLEEP: begin
        // qualifying events, or clearing auto-sleep enable, wake the device
        if (activity_i || !s.ctrl_two[BIT_SLP_EN]) begin
          next_s.mode     = ACSC_WAKE;
          next_s.rate_cnt = 14'h0000;
        end
      end
      ACSC_BOOT: begin
        // reset bit drops when boot is done
        if (s.boot_cnt == BOOT_CYCLES - 5'h01) begin
          next_s.mode              = ACSC_STANDBY;
          next_s.ctrl_two[BIT_SW_RESET] = 1'b0;
        end else begin
          next_s.boot_cnt     = s.boot_cnt + 5'h01;
          next_s.serial_reset = 1'b1;
        end
      end
      default: next_s.mode = ACSC_STANDBY;
    endcase

    // qualifying activity restarts the inactivity timer
    if (activity_i || s.mode != ACSC_WAKE || next_s.mode != ACSC_WAKE) begin
      next_s.step_tick = 10'h000;
      next_s.steps     = 8'h00;
    end
    if (s.mode != ACSC_BOOT && !s.ctrl_one[BIT_MODE]) begin
      next_s.mode     = ACSC_STANDBY;
      next_s.rate_cnt = 14'h0000;
    end

    // register writes are ignored while booting
    if (req_i.wr && s.mode != ACSC_BOOT) begin
      // other fields assumed changed only in standby
      if (req_i.addr == ADDR_CTRL_ONE) begin
        next_s.ctrl_one = req_i.wdata & CTRL_ONE_WMASK;
      end
      if (req_i.addr == ADDR_CTRL_TWO) begin
        next_s.ctrl_two = req_i.wdata & CTRL_TWO_WMASK;
        // software reset wins in every mode except boot, where the write is ignored
        if (req_i.wdata[BIT_SW_RESET]) begin
          next_s          = '0;
          next_s.ctrl_one = CTRL_ONE_RESET;
          next_s.ctrl_two = CTRL_TWO_RESET | 8'(1 << BIT_SW_RESET);
          next_s.mode     = ACSC_BOOT;
          next_s.serial_reset = 1'b1;
        end
      end
    end

    // register reads, and address auto-increment
    if (req_i.rd) begin
      case (req_i.addr)
        ADDR_CTRL_ONE: next_s.rdata = s.ctrl_one;
        ADDR_CTRL_TWO: next_s.rdata = s.ctrl_two & CTRL_TWO_RMASK;
        default:       next_s.rdata = 8'h00;
      endcase
    end
    if (req_i.rd || req_i.wr) begin
      inc = req_i.addr + 8'h01;
      // fast read jumps over the low data bytes
      if (s.ctrl_one[BIT_FAST_READ] && is_low_byte(inc)) begin
        inc = inc + 8'h01;
      end
      next_s.next_addr = inc;
    end
    if (next_s.mode == ACSC_BOOT) begin
      next_s.next_addr = 8'h00;
    end

    // scheme follows the mode in use
    next_s.sleeping = (next_s.mode == ACSC_SLEEP);
    next_s.scheme   = next_s.sleeping ? next_s.ctrl_two[POS_SLP_PS +: 2]
                                      : next_s.ctrl_two[POS_WAKE_PS +: 2];
    next_s.os_ratio = os_ratio(next_s.scheme, next_s.sleeping
                               ? sleep_row(next_s.ctrl_one[POS_SLP_RATE +: 2])
                               : wake_row(next_s.ctrl_one[POS_WAKE_RATE +: 3]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign rdata_o        = s.rdata;
  assign next_addr_o    = s.next_addr;
  assign serial_reset_o = s.serial_reset;
  assign sample_tick_o  = s.sample_tick;
  assign sleeping_o     = s.sleeping;
  assign booting_o      = (s.ctrl_two[BIT_SW_RESET]);
  assign os_ratio_o     = s.os_ratio;
  assign power_scheme_o = s.scheme;
  // self-test drive to the sensing path
  assign self_test_o    = s.ctrl_two[BIT_SELF_TEST];
  assign fast_read_o    = s.ctrl_one[BIT_FAST_READ];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sw_reset_boot_a: assert property (
    (req_i.wr && req_i.addr == ADDR_CTRL_TWO && req_i.wdata[BIT_SW_RESET] && !booting_o)
    |=> booting_o && serial_reset_o && s.ctrl_one == CTRL_ONE_RESET)
    else $error("software reset did not start boot");
  boot_defaults_a: assert property (
    $fell(booting_o) |-> s.ctrl_one == CTRL_ONE_RESET && !self_test_o && !sleeping_o)
    else $error("registers not at defaults after boot");
  serial_held_a: assert property (
    $rose(booting_o) |-> serial_reset_o [*8])
    else $error("serial reset not held in boot");
  // reset bit reads zero and drops in time
  rst_reads_zero_a: assert property (
    (req_i.rd && req_i.addr == ADDR_CTRL_TWO) |=> !rdata_o[BIT_SW_RESET])
    else $error("reset bit read as one");
  boot_ends_a: assert property (
    $rose(booting_o) |-> ##[15:17] !booting_o)
    else $error("boot did not end in time");
  no_sleep_off_a: assert property (
    !s.ctrl_two[BIT_SLP_EN] |=> !sleeping_o)
    else $error("slept with auto-sleep off");
  activity_wakes_a: assert property (
    (sleeping_o && activity_i && !req_i.wr) |=> !sleeping_o)
    else $error("activity did not wake");
  standby_quiet_a: assert property (
    (!s.ctrl_one[BIT_MODE] && s.mode == ACSC_STANDBY) |=> !sample_tick_o)
    else $error("sample tick in standby");
  unused_zero_a: assert property (
    s.ctrl_one[2] == 1'b0 && s.ctrl_two[5] == 1'b0)
    else $error("unused bit set");
  hires_ratio_a: assert property (
    (power_scheme_o == 2'b10 && !sleeping_o && s.ctrl_one[POS_WAKE_RATE +: 3] == 3'h7
     && $stable(s.ctrl_one)) |-> os_ratio_o == 11'h400)
    else $error("wrong high resolution ratio");
endmodule

/* File: dv/acsc_host_model.sv */
// host side model that issues byte requests to the register pair
module acsc_host_model
  import acsc_pkg::*;
(
  // clock
  input  wire logic clk_i,
  // requests towards the register block
  output acsc_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial req_o = '0;

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle strobe launched off the falling edge, held over one rising edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_i);
    // released lines show the inverse so stale values never pass
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

/* File: dv/accel_system_control_regs_tb_top.sv */
// self-checking bench of the system control register pair
module accel_system_control_regs_tb_top
  import acsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TICK = 4;  // short base tick keeps slow rates affordable
  localparam int PER [8] = '{1, 2, 4, 8, 16, 64, 128, 512};
  localparam logic [10:0] OS_TAB [4][8] = '{
    '{11'h002, 11'h004, 11'h004, 11'h004, 11'h004, 11'h010, 11'h020, 11'h080},
    '{11'h002, 11'h004, 11'h004, 11'h004, 11'h004, 11'h004, 11'h008, 11'h020},
    '{11'h002, 11'h004, 11'h008, 11'h010, 11'h020, 11'h080, 11'h100, 11'h400},
    '{11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h002, 11'h004, 11'h010}};

  logic        clk_i;
  logic        resetn_i;
  acsc_req_t   req;
  logic [7:0]  inactivity_period_i;
  logic        activity_i;
  logic [7:0]  rdata;
  logic [7:0]  next_addr;
  logic        serial_reset;
  logic        sample_tick;
  logic        sleeping;
  logic        booting;
  logic [10:0] os_ratio;
  logic [1:0]  scheme;
  logic        self_test;
  logic        fast_read;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          n;
  int          k;
  logic [7:0]  exp_q [$];
  logic [31:0] seed;
  logic [1:0]  s;

  acsc_regs #(.BASE_TICK_CYCLES(TICK)) u_acsc_regs (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
    .inactivity_period_i(inactivity_period_i), .activity_i(activity_i),
    .rdata_o(rdata), .next_addr_o(next_addr), .serial_reset_o(serial_reset),
    .sample_tick_o(sample_tick), .sleeping_o(sleeping), .booting_o(booting),
    .os_ratio_o(os_ratio), .power_scheme_o(scheme), .self_test_o(self_test),
    .fast_read_o(fast_read));

  acsc_host_model u_acsc_host_model (.clk_i(clk_i), .req_o(req));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_acsc_host_model.access(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_acsc_host_model.access(1'b1, a, d);
  endtask

  // gap in cycles between two sample pulses, bounded
  task automatic tick_gap(output int g);
    int j;
    j = 0;
    while (sample_tick !== 1'b1 && j < 5000) begin
      @(negedge clk_i);
      j++;
    end
    @(negedge clk_i);
    g = 1;
    while (sample_tick !== 1'b1 && g < 5000) begin
      @(negedge clk_i);
      g++;
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read monitor: data lands on the taken edge, checked on the falling edge after it
  always @(posedge clk_i) begin
    if (req.rd === 1'b1) begin
      @(negedge clk_i);
      chk("rdata", 16'(exp_q.pop_front()), 16'(rdata));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    resetn_i = 1'b0;
    inactivity_period_i = 8'h00;
    activity_i = 1'b0;
    seed = 32'h00004B72;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    rd_chk(ADDR_CTRL_ONE, 8'h00);
    rd_chk(ADDR_CTRL_TWO, 8'h00);
    rd_chk(8'h10, 8'h00);
    // fields of the first register change only while in standby
    wr(ADDR_CTRL_ONE, 8'hFE);
    wr(ADDR_CTRL_TWO, 8'hBF);
    rd_chk(ADDR_CTRL_ONE, 8'hFA);
    rd_chk(ADDR_CTRL_TWO, 8'h9F);
    chk("fast_read", 16'h0001, 16'(fast_read));
    chk("self_test", 16'h0001, 16'(self_test));
    for (int i = 1; i < 8; i += 2) begin
      rd_chk(8'(i), 8'h00);
      chk("next_addr", (i == 7) ? 16'h0008 : 16'(i + 2), 16'(next_addr));
    end
    // software reset, then a write that boot must swallow
    wr(ADDR_CTRL_TWO, 8'h40);
    chk("booting", 16'h0001, 16'(booting));
    chk("serial_reset", 16'h0001, 16'(serial_reset));
    wr(ADDR_CTRL_ONE, 8'h02);
    k = 0;
    while (booting !== 1'b0 && k < 40) begin
      @(negedge clk_i);
      k++;
    end
    chk("boot_done", 16'h0000, 16'(booting));
    rd_chk(ADDR_CTRL_ONE, 8'h00);
    rd_chk(ADDR_CTRL_TWO, 8'h00);
    chk("fast_read", 16'h0000, 16'(fast_read));
    // every wake rate with a random power scheme
    for (int c = 0; c < 8; c++) begin
      seed = xs(seed);
      s = seed[1:0];
      wr(ADDR_CTRL_ONE, {2'b00, 3'(c), 3'b000});
      wr(ADDR_CTRL_TWO, {6'b000000, s});
      wr(ADDR_CTRL_ONE, {2'b00, 3'(c), 3'b001});
      tick_gap(n);
      tick_gap(n);
      chk("period", 16'(PER[c] * TICK), 16'(n));
      chk("os_ratio", 16'(OS_TAB[s][c]), 16'(os_ratio));
      chk("scheme", 16'(s), 16'(scheme));
      // only the mode bit changes while active
      wr(ADDR_CTRL_ONE, {2'b00, 3'(c), 3'b000});
    end
    // auto-sleep after one inactivity step, then wake on activity
    inactivity_period_i = 8'h01;
    wr(ADDR_CTRL_TWO, 8'h14);
    // sleep rate codes 00 (50 Hz) and 01 (12.5 Hz)
    for (int r = 0; r < 2; r++) begin
      wr(ADDR_CTRL_ONE, {2'(r), 6'h01});
      k = 0;
      while (sleeping !== 1'b1 && k < 2000) begin
        @(negedge clk_i);
        k++;
      end
      chk("sleep_delay", 16'h0001, 16'(k >= 1000 && k <= 1050));
      tick_gap(n);
      tick_gap(n);
      chk("sleep_period", 16'((r == 0 ? 16 : 64) * TICK), 16'(n));
      chk("sleep_os", (r == 0) ? 16'h0020 : 16'h0080, 16'(os_ratio));
      chk("sleep_scheme", 16'h0002, 16'(scheme));
      activity_i = 1'b1;
      @(negedge clk_i);
      activity_i = 1'b0;
      chk("sleeping", 16'h0000, 16'(sleeping));
      // back to standby before the next field change
      wr(ADDR_CTRL_ONE, {2'(r), 6'h00});
    end
    final_report();
  end
endmodule
